// ### design/heartbeat_gen.sv
/*
 * free-running heartbeat toggle with a programmable half period.
 * assumes one reference clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "motion_status_consts.svh"

module heartbeat_gen #(
    parameter logic [`HB_CNT_W-1:0] HALF_PERIOD =
        `HB_CNT_W'(`HEARTBEAT_CYCLES)
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // heartbeat level
    output var  logic o_beat
);
    typedef struct packed {
        logic [`HB_CNT_W-1:0] cnt;
        logic                 beat;
    } hb_state_t;

    hb_state_t st_r;
    hb_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (st_r.cnt >= HALF_PERIOD - `HB_CNT_W'(1)) begin
            st_nxt.cnt  = '0;
            st_nxt.beat = ~st_r.beat;
        end else begin
            st_nxt.cnt = st_r.cnt + `HB_CNT_W'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_beat = st_r.beat;

    hb_period_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (st_r.cnt == HALF_PERIOD - `HB_CNT_W'(1)) |=> $changed(o_beat))
        else $error("heartbeat did not toggle at half period");
endmodule : heartbeat_gen
`default_nettype wire

// ### design/motion_status_consts.svh
/*
 * constants for the motion status words: bit positions, command codes,
 * heartbeat timing.
 * assumes a 100 MHz reference clock.
 */
`ifndef MOTION_STATUS_CONSTS_SVH
`define MOTION_STATUS_CONSTS_SVH

// status word one bit positions
`define SW1_MODE        15
`define SW1_HEALTHY     14
`define SW1_SETUP_FAULT 13
`define SW1_BAD_REQ     12
`define SW1_INPUT_FAULT 11
`define SW1_POS_INVALID 10
`define SW1_SEG_READY   9
`define SW1_PROF_READY  8
`define SW1_MOVE_DONE   7
`define SW1_DECEL       6
`define SW1_ACCEL       5
`define SW1_HOMED       4
`define SW1_STOPPED     3
`define SW1_HOLD        2
`define SW1_CCW         1
`define SW1_CW          0

// status word two bit positions
`define SW2_DRV_EN      15
`define SW2_STALL       14
`define SW2_OUT1        13
`define SW2_HEARTBEAT   11
`define SW2_LIMIT       10
`define SW2_BAD_PARAM   9
`define SW2_LAG         8
`define SW2_DRV_FAULT   7
`define SW2_NET_LOST    6
`define SW2_PLC_STATE   5
`define SW2_TEMP_WARN   4
`define SW2_IN3         2
`define SW2_IN2         1
`define SW2_IN1         0

// command word codes and bits
`define CMD_MSW_RESET_ERR_BIT  10
`define CMD_MSW_SEGMENT_BIT    12
`define CMD_MSW_FIRST_BLOCK    16'h0800
`define CMD_MSW_SEGMENT_BLOCK  16'h1800
`define CMD_DRV_FAULT_CLEAR    16'h0400
`define CMD_LSW_DRV_EN_BIT     15

// heartbeat half period
`define HEARTBEAT_MS      500
`define REF_CLK_MHZ       100
`define HEARTBEAT_CYCLES  (`HEARTBEAT_MS * 1000 * `REF_CLK_MHZ)
`define HB_CNT_W          26
`define WORD_ZERO         16'h0000

`endif

// ### design/motion_status_pkg.sv
/*
 * types for the motion status words.
 * assumes the constants header is included by its users.
 */
package motion_status_pkg;
    typedef logic [15:0] status_word_t;
    typedef enum logic [1:0] {
        SEG_IDLE,
        SEG_READY,
        SEG_TAKEN
    } seg_state_t;
endpackage : motion_status_pkg

// ### design/motion_status_words.sv
/*
 * two status words of a stepper indexer in command mode, with sticky
 * fault flags, segment handshake and driver-fault clear exchange.
 * assumes motion, configuration, fault and network events come from logic on the
 * same clock as one-cycle pulses or levels; raw input pins are synced here.
 */
// Contract
// - bit 15 shows configuration mode; motor and commands held until config valid.
// - bit 14 high when healthy, low on any internal fault.
// - bit 13 set at power-up and bad config; cleared by valid config.
// - bit 13 also set with stall detection in configuration mode.
// - bit 12 set on bad command; cleared only by reset-errors.
// - bit 11 set on emergency stop, limit, manual into limit, homing overtravel.
// - bit 10 set on config, reconnect, stops, limit, stall; blocks absolute.
// - bit 8 ready for profile programming, bit 9 ready for segment.
// - bit 7 set on clean move end; cleared by move, preset, reset.
// - bit 7 also set with bit 12 on bad manual or registration params.
// - bit 6 while decelerating, bit 5 while accelerating, else zero.
// - bit 4 high after successful homing, zero otherwise.
// - bit 3 high whenever motor is not moving.
// - bit 2 hold reached; bits 1 and 0 show ccw and cw.
// - word two bit 15 mirrors driver enable; current gated by faults.
// - bit 14 stall, bit 13 output 1, bits 12 and 3 zero.
// - word two bit 11 toggles about every 500 ms.
// - bit 10 set on limit in move; cleared by release or reset.
// - bit 9 set on bad manual change or gearing term out of range.
// - bit 7 driver fault; cleared by both command words 0x0400.
// - bit 6 and input fault set on physical reconnect only.
// - bits 2..0 show inputs 3..1; bit 8 shows rotor lag.
// - segment block clears segment ready; host clears bit 12 to rearm.
`timescale 1ns/1ps
`default_nettype none
`include "motion_status_consts.svh"

module motion_status_words
    import motion_status_pkg::*;
#(
    parameter logic [`HB_CNT_W-1:0] HB_HALF_PERIOD =
        `HB_CNT_W'(`HEARTBEAT_CYCLES)
) (
    // clock and reset
    input  wire logic         I_REF_CLK,
    input  wire logic         I_RST_N,
    // command block from host
    input  wire logic         I_CMD_VALID,
    input  wire logic [15:0]  I_CMD_MSW,
    input  wire logic [15:0]  I_CMD_LSW,
    input  wire logic         I_CMD_INVALID,
    input  wire logic         I_CMD_IS_MOVE,
    input  wire logic         I_CMD_IS_PRESET,
    input  wire logic         I_CMD_IS_HOME,
    input  wire logic         I_CMD_IS_ABS,
    input  wire logic         I_CMD_PARAM_RANGE_ERR,
    // configuration events
    input  wire logic         I_CFG_MODE,
    input  wire logic         I_CFG_WRITE_OK,
    input  wire logic         I_CFG_WRITE_BAD,
    input  wire logic         I_CFG_FLASH_OK,
    input  wire logic         I_STALL_DET_EN,
    // motion engine state
    input  wire logic         I_INT_FAULT,
    input  wire logic         I_MOVING,
    input  wire logic         I_ACCEL,
    input  wire logic         I_DECEL,
    input  wire logic         I_DIR_CCW,
    input  wire logic         I_HOLD,
    input  wire logic         I_MOVE_DONE,
    input  wire logic         I_HOME_DONE,
    input  wire logic         I_HOMING,
    input  wire logic         I_MANUAL,
    input  wire logic         I_IMM_STOP,
    input  wire logic         I_STALL,
    input  wire logic         I_LAG,
    input  wire logic         I_PARAM_CHANGE_BAD,
    input  wire logic         I_GEAR_BAD,
    input  wire logic         I_IDLE_ZERO_CUR,
    // network events
    input  wire logic         I_NET_RECONNECT_PHYS,
    input  wire logic         I_NET_RECONNECT_OTHER,
    // raw pins
    input  wire logic         I_ESTOP_PIN,
    input  wire logic         I_LIMIT_CW_PIN,
    input  wire logic         I_LIMIT_CCW_PIN,
    input  wire logic [2:0]   I_IN_PINS,
    input  wire logic         I_OVER_TEMP_PIN,
    input  wire logic         I_SHORT_PIN,
    input  wire logic         I_OUT1_FB_PIN,
    // status words
    output var  logic [15:0]  O_STATUS_W1,
    output var  logic [15:0]  O_STATUS_W2,
    // motor and command gating
    output logic              O_MOTOR_CURRENT_EN,
    output logic              O_CMD_ACCEPT,
    output logic              O_ABS_REFUSED
);
    localparam int NSYNC = 9;

    typedef struct packed {
        logic [NSYNC-1:0] s1;
        logic [NSYNC-1:0] s2;
        logic             lim_prev;
        seg_state_t       seg;
        logic             prof_ready;
        logic             setup_fault;
        logic             bad_req;
        logic             input_fault;
        logic             pos_invalid;
        logic             move_done;
        logic             homed;
        logic             drv_en;
        logic             limit_hit;
        logic             bad_param;
        logic             drv_fault;
        logic             net_lost;
        status_word_t     w1;
        status_word_t     w2;
    } ms_state_t;

    ms_state_t st_r;
    ms_state_t st_nxt;
    logic      beat;

    function automatic logic is_reset_errors(input logic [15:0] msw);
        return msw[`CMD_MSW_RESET_ERR_BIT];
    endfunction

    heartbeat_gen #(
        .HALF_PERIOD (HB_HALF_PERIOD)
    ) u_hb (
        .i_clk   (I_REF_CLK),
        .i_rst_n (I_RST_N),
        .o_beat  (beat)
    );

    logic [NSYNC-1:0] pins_raw;
    assign pins_raw = {I_OUT1_FB_PIN, I_SHORT_PIN, I_OVER_TEMP_PIN,
                       I_IN_PINS, I_LIMIT_CCW_PIN, I_LIMIT_CW_PIN,
                       I_ESTOP_PIN};

    logic       estop;
    logic       lim_any;
    logic       lim_toward;
    logic [2:0] ins;
    logic       over_temp;
    logic       short_ck;
    logic       out1;
    logic       cmd_ok;
    logic       rst_err;
    logic       drv_clear;
    logic       lim_in_move;
    logic       stop_evt;

    always_comb begin
        estop     = st_r.s2[0];
        lim_any   = st_r.s2[1] | st_r.s2[2];
        ins       = st_r.s2[5:3];
        over_temp = st_r.s2[6];
        short_ck  = st_r.s2[7];
        out1      = st_r.s2[8];
        lim_toward = I_DIR_CCW ? st_r.s2[2] : st_r.s2[1];
        cmd_ok    = I_CMD_VALID & ~I_CFG_MODE & ~st_r.setup_fault;
        rst_err   = cmd_ok & is_reset_errors(I_CMD_MSW);
        drv_clear = I_CMD_VALID & (I_CMD_MSW == `CMD_DRV_FAULT_CLEAR) &
                    (I_CMD_LSW == `CMD_DRV_FAULT_CLEAR);
        lim_in_move = I_MOVING & lim_any & ~I_HOMING;
        stop_evt  = I_IMM_STOP | estop;
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pins_raw;
        st_nxt.s2 = st_r.s1;
        st_nxt.lim_prev = lim_any;

        if (I_CFG_WRITE_OK | I_CFG_FLASH_OK) begin
            st_nxt.setup_fault = 1'b0;
        end
        if (I_CFG_WRITE_BAD) begin
            st_nxt.setup_fault = 1'b1;
        end

        if (rst_err) begin
            st_nxt.bad_req = 1'b0;
        end
        if (cmd_ok & (I_CMD_INVALID | I_CMD_PARAM_RANGE_ERR)) begin
            st_nxt.bad_req = 1'b1;
        end

        if (rst_err) begin
            st_nxt.input_fault = 1'b0;
        end
        if (estop | (lim_in_move) |
            (cmd_ok & I_CMD_IS_MOVE & I_MANUAL & lim_toward) |
            (I_HOMING & lim_any & I_MOVING) | I_NET_RECONNECT_PHYS) begin
            st_nxt.input_fault = 1'b1;
        end

        if (cmd_ok & I_CMD_IS_PRESET & ~I_CMD_INVALID) begin
            st_nxt.pos_invalid = 1'b0;
        end
        if (I_HOME_DONE) begin
            st_nxt.pos_invalid = 1'b0;
        end
        if (I_CFG_WRITE_OK | I_CFG_WRITE_BAD | I_NET_RECONNECT_PHYS |
            I_NET_RECONNECT_OTHER | stop_evt | lim_in_move | I_STALL) begin
            st_nxt.pos_invalid = 1'b1;
        end

        if (rst_err | (cmd_ok & (I_CMD_IS_MOVE | I_CMD_IS_PRESET))) begin
            st_nxt.move_done = 1'b0;
        end
        if (I_MOVE_DONE | (cmd_ok & I_CMD_PARAM_RANGE_ERR)) begin
            st_nxt.move_done = 1'b1;
        end

        if (cmd_ok & (I_CMD_IS_MOVE | I_CMD_IS_HOME | I_CMD_IS_PRESET)) begin
            st_nxt.homed = 1'b0;
        end
        if (I_HOME_DONE) begin
            st_nxt.homed = 1'b1;
        end

        if (I_CMD_VALID) begin
            st_nxt.drv_en = I_CMD_LSW[`CMD_LSW_DRV_EN_BIT];
        end

        if (rst_err | (st_r.lim_prev & ~lim_any)) begin
            st_nxt.limit_hit = 1'b0;
        end
        if (I_MOVING & lim_any) begin
            st_nxt.limit_hit = 1'b1;
        end

        if (rst_err) begin
            st_nxt.bad_param = 1'b0;
        end
        if ((I_MANUAL & I_PARAM_CHANGE_BAD) | I_GEAR_BAD) begin
            st_nxt.bad_param = 1'b1;
        end

        if (drv_clear) begin
            st_nxt.drv_fault = 1'b0;
        end
        if (st_r.drv_en & (over_temp | short_ck)) begin
            st_nxt.drv_fault = 1'b1;
        end

        if (rst_err) begin
            st_nxt.net_lost = 1'b0;
        end
        if (I_NET_RECONNECT_PHYS) begin
            st_nxt.net_lost = 1'b1;
        end

        if (cmd_ok & (I_CMD_MSW == `CMD_MSW_FIRST_BLOCK)) begin
            st_nxt.prof_ready = 1'b1;
            st_nxt.seg        = SEG_READY;
        end
        if (I_MOVING | rst_err) begin
            st_nxt.prof_ready = 1'b0;
            st_nxt.seg        = SEG_IDLE;
        end
        case (st_r.seg)
            SEG_READY: begin
                if (cmd_ok & (I_CMD_MSW == `CMD_MSW_SEGMENT_BLOCK)) begin
                    st_nxt.seg = SEG_TAKEN;
                end
            end
            SEG_TAKEN: begin
                if (I_CMD_VALID & ~I_CMD_MSW[`CMD_MSW_SEGMENT_BIT]) begin
                    st_nxt.seg = SEG_READY;
                end
            end
            default: begin
            end
        endcase

        st_nxt.w1[`SW1_MODE]        = I_CFG_MODE;
        st_nxt.w1[`SW1_HEALTHY]     = ~I_INT_FAULT;
        st_nxt.w1[`SW1_SETUP_FAULT] = st_nxt.setup_fault |
                                      (I_STALL_DET_EN & I_CFG_MODE);
        st_nxt.w1[`SW1_BAD_REQ]     = st_nxt.bad_req;
        st_nxt.w1[`SW1_INPUT_FAULT] = st_nxt.input_fault;
        st_nxt.w1[`SW1_POS_INVALID] = st_nxt.pos_invalid;
        st_nxt.w1[`SW1_SEG_READY]   = (st_nxt.seg == SEG_READY);
        st_nxt.w1[`SW1_PROF_READY]  = st_nxt.prof_ready;
        st_nxt.w1[`SW1_MOVE_DONE]   = st_nxt.move_done;
        st_nxt.w1[`SW1_DECEL]       = I_MOVING & I_DECEL;
        st_nxt.w1[`SW1_ACCEL]       = I_MOVING & I_ACCEL & ~I_DECEL;
        st_nxt.w1[`SW1_HOMED]       = st_nxt.homed;
        st_nxt.w1[`SW1_STOPPED]     = ~I_MOVING;
        st_nxt.w1[`SW1_HOLD]        = I_HOLD;
        st_nxt.w1[`SW1_CCW]         = I_MOVING & I_DIR_CCW;
        st_nxt.w1[`SW1_CW]          = I_MOVING & ~I_DIR_CCW;

        st_nxt.w2                   = `WORD_ZERO;
        st_nxt.w2[`SW2_DRV_EN]      = st_nxt.drv_en;
        st_nxt.w2[`SW2_STALL]       = I_STALL;
        st_nxt.w2[`SW2_OUT1]        = out1;
        st_nxt.w2[`SW2_HEARTBEAT]   = beat;
        st_nxt.w2[`SW2_LIMIT]       = st_nxt.limit_hit;
        st_nxt.w2[`SW2_BAD_PARAM]   = st_nxt.bad_param;
        st_nxt.w2[`SW2_LAG]         = I_LAG;
        st_nxt.w2[`SW2_DRV_FAULT]   = st_nxt.drv_fault;
        st_nxt.w2[`SW2_NET_LOST]    = st_nxt.net_lost;
        st_nxt.w2[`SW2_IN3]         = ins[2];
        st_nxt.w2[`SW2_IN2]         = ins[1];
        st_nxt.w2[`SW2_IN1]         = ins[0];
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            st_r             <= '0;
            st_r.setup_fault <= 1'b1;
            st_r.pos_invalid <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign O_STATUS_W1 = st_r.w1;
    assign O_STATUS_W2 = st_r.w2;
    // current gating, kept under emergency stop
    assign O_MOTOR_CURRENT_EN = st_r.drv_en & ~st_r.drv_fault &
                                ~st_r.setup_fault &
                                ~(~I_MOVING & I_IDLE_ZERO_CUR);
    assign O_CMD_ACCEPT  = cmd_ok;
    assign O_ABS_REFUSED = I_CMD_VALID & I_CMD_IS_ABS & st_r.pos_invalid;

    bad_req_hold_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
        (st_r.bad_req && !rst_err) |=> st_r.bad_req)
        else $error("bad request flag dropped without reset");
    range_err_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
        (cmd_ok && I_CMD_PARAM_RANGE_ERR) |=> (O_STATUS_W1[`SW1_BAD_REQ] &&
        O_STATUS_W1[`SW1_MOVE_DONE]))
        else $error("range error did not set both flags");
    stopped_bit_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
        $past(I_MOVING) |-> !O_STATUS_W1[`SW1_STOPPED])
        else $error("stopped bit set while moving");
    phase_excl_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
        !(O_STATUS_W1[`SW1_DECEL] && O_STATUS_W1[`SW1_ACCEL]))
        else $error("accel and decel both set");
    reserved_zero_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
        !O_STATUS_W2[12] && !O_STATUS_W2[3])
        else $error("reserved bit set");
    drv_clear_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
        (drv_clear && !(st_r.drv_en && (over_temp || short_ck)))
        |=> !O_STATUS_W2[`SW2_DRV_FAULT])
        else $error("driver fault not cleared");
    net_lost_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
        I_NET_RECONNECT_PHYS |=> (O_STATUS_W2[`SW2_NET_LOST] &&
        O_STATUS_W1[`SW1_INPUT_FAULT]))
        else $error("reconnect flags missing");
    abs_refuse_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
        (I_CMD_VALID && I_CMD_IS_ABS && O_STATUS_W1[`SW1_POS_INVALID])
        |-> O_ABS_REFUSED)
        else $error("absolute move not refused");
    sequence seg_take_s;
        O_STATUS_W1[`SW1_SEG_READY] && cmd_ok &&
        (I_CMD_MSW == `CMD_MSW_SEGMENT_BLOCK) && !I_MOVING && !rst_err;
    endsequence
    seg_take_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
        seg_take_s |=> !O_STATUS_W1[`SW1_SEG_READY])
        else $error("segment ready not cleared");
endmodule : motion_status_words
`default_nettype wire

// ### tb/host_cmd_model.sv
/*
 * host controller model: writes one command block at a time.
 * assumes the device takes the block on the rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model (
    // clock
    input  wire logic        i_clk,
    // command block
    output var  logic        o_valid,
    output var  logic [15:0] o_msw,
    output var  logic [15:0] o_lsw
);
    initial begin
        o_valid = 1'b0;
        o_msw   = 16'h0000;
        o_lsw   = 16'hFFFF;
    end
    // one block per cycle, words scrambled outside it
    task automatic send(input logic [15:0] msw, input logic [15:0] lsw);
        @(negedge i_clk);
        o_valid = 1'b1;
        o_msw   = msw;
        o_lsw   = lsw;
        @(negedge i_clk);
        o_valid = 1'b0;
        o_msw   = ~msw;
        o_lsw   = ~lsw;
    endtask : send
endmodule : host_cmd_model
`default_nettype wire

// ### tb/motion_status_words_tb.sv
/*
 * self-checking bench for the motion status words.
 * assumes inputs change on the falling edge, short heartbeat period.
 */
`timescale 1ns/1ps
`default_nettype none
module motion_status_words_tb;
    import motion_status_pkg::*;
    typedef struct packed {
        logic [3:0]  idx;
        logic        w2;
        logic        lvl;
        logic [15:0] mask;
        logic [15:0] want;
    } ev_t;
    logic         clk, rst_n, cv, bad, mv, rng, cfg, cfg_ok, st_en;
    logic         moving, accel, decel, ccw, done, otemp, cur_en, acc;
    logic         abs_cmd, prs, shrt, refused;
    logic [2:0]   pins;
    logic [15:0]  ev, msw, lsw;
    status_word_t w1, w2;
    int           num_errors, checked, cycles;
    ev_t          tbl [12] = '{
        '{4'h0, 1'b1, 1'b0, 16'h0040, 16'h0000},
        '{4'h1, 1'b1, 1'b0, 16'h0040, 16'h0040},
        '{4'h2, 1'b1, 1'b0, 16'h0200, 16'h0200},
        '{4'h3, 1'b0, 1'b0, 16'h0410, 16'h0010},
        '{4'h4, 1'b0, 1'b0, 16'h0400, 16'h0400},
        '{4'h5, 1'b1, 1'b1, 16'h4000, 16'h4000},
        '{4'h6, 1'b1, 1'b1, 16'h0100, 16'h0100},
        '{4'h7, 1'b0, 1'b1, 16'h0004, 16'h0004},
        '{4'h8, 1'b0, 1'b1, 16'h4000, 16'h0000},
        '{4'h9, 1'b1, 1'b1, 16'h2000, 16'h2000},
        '{4'hA, 1'b0, 1'b1, 16'h0800, 16'h0800},
        '{4'hB, 1'b0, 1'b0, 16'h2000, 16'h2000}};

    host_cmd_model host (.i_clk(clk), .o_valid(cv), .o_msw(msw), .o_lsw(lsw));

    motion_status_words #(.HB_HALF_PERIOD(26'h10)) dut (
        .I_REF_CLK(clk), .I_RST_N(rst_n), .I_CMD_VALID(cv),
        .I_CMD_MSW(msw), .I_CMD_LSW(lsw), .I_CMD_INVALID(bad),
        .I_CMD_IS_MOVE(mv), .I_CMD_IS_PRESET(prs), .I_CMD_IS_HOME(1'b0),
        .I_CMD_IS_ABS(abs_cmd), .I_CMD_PARAM_RANGE_ERR(rng),
        .I_CFG_MODE(cfg), .I_CFG_WRITE_OK(cfg_ok), .I_CFG_WRITE_BAD(ev[11]),
        .I_CFG_FLASH_OK(1'b0), .I_STALL_DET_EN(st_en), .I_INT_FAULT(ev[8]),
        .I_MOVING(moving), .I_ACCEL(accel), .I_DECEL(decel), .I_DIR_CCW(ccw),
        .I_HOLD(ev[7]), .I_MOVE_DONE(done), .I_HOME_DONE(ev[3]),
        .I_HOMING(ev[14]), .I_MANUAL(ev[15]), .I_IMM_STOP(ev[4]),
        .I_STALL(ev[5]), .I_LAG(ev[6]), .I_PARAM_CHANGE_BAD(ev[12]),
        .I_GEAR_BAD(ev[2]), .I_IDLE_ZERO_CUR(1'b0),
        .I_NET_RECONNECT_PHYS(ev[1]), .I_NET_RECONNECT_OTHER(ev[0]),
        .I_ESTOP_PIN(ev[10]), .I_LIMIT_CW_PIN(ev[13]),
        .I_LIMIT_CCW_PIN(1'b0), .I_IN_PINS(pins), .I_OVER_TEMP_PIN(otemp),
        .I_SHORT_PIN(shrt), .I_OUT1_FB_PIN(ev[9]), .O_STATUS_W1(w1),
        .O_STATUS_W2(w2), .O_MOTOR_CURRENT_EN(cur_en), .O_CMD_ACCEPT(acc),
        .O_ABS_REFUSED(refused));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            $display("Error timeout expected done seen running");
            end_of_test();
        end
    end

    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic t_reset;
        chk("w1 reset", 16'h6408, w1);
        chk("w2 reset", 16'h0000, w2 & 16'hF7FF);
        bad = 1'b1;
        fork
            host.send(16'h0000, 16'h0000);
            begin
                @(posedge cv);
                #1 chk("accept", 16'h0000, 16'(acc));
            end
        join
        bad = 1'b0;
        chk("refused err", 16'h0000, w1 & 16'h1000);
    endtask : t_reset

    task automatic t_config;
        cfg = 1'b1;
        @(negedge clk);
        chk("mode", 16'h8000, w1 & 16'h8000);
        cfg_ok = 1'b1;
        @(negedge clk);
        cfg_ok = 1'b0;
        st_en = 1'b1;
        @(negedge clk);
        chk("stall cfg", 16'hA000, w1 & 16'hA000);
        cfg = 1'b0;
        st_en = 1'b0;
        @(negedge clk);
        chk("cfg ok", 16'h0400, w1 & 16'hA400);
    endtask : t_config

    task automatic t_errors;
        bad = 1'b1;
        host.send(16'h0000, 16'h0000);
        bad = 1'b0;
        chk("bad cmd", 16'h1000, w1 & 16'h1080);
        host.send(16'h0000, 16'h0000);
        chk("err held", 16'h1000, w1 & 16'h1080);
        {bad, rng} = 2'b11;
        host.send(16'h0000, 16'h0000);
        {bad, rng} = 2'b00;
        chk("range err", 16'h1080, w1 & 16'h1080);
        host.send(16'h0400, 16'h0000);
        chk("reset err", 16'h0000, w1 & 16'h1080);
    endtask : t_errors

    task automatic t_motion;
        {moving, accel} = 2'b11;
        @(negedge clk);
        chk("accel cw", 16'h0021, w1 & 16'h006B);
        {accel, decel, ccw} = 3'b011;
        @(negedge clk);
        chk("decel ccw", 16'h0042, w1 & 16'h006B);
        {moving, decel, done} = 3'b001;
        @(negedge clk);
        done = 1'b0;
        chk("done", 16'h0088, w1 & 16'h00EB);
        mv = 1'b1;
        host.send(16'h0000, 16'h0000);
        mv = 1'b0;
        chk("next move", 16'h0000, w1 & 16'h0080);
    endtask : t_motion

    task automatic t_segment;
        host.send(16'h0800, 16'h0000);
        chk("first blk", 16'h0300, w1 & 16'h0300);
        host.send(16'h1800, 16'h0000);
        chk("seg taken", 16'h0000, w1 & 16'h0200);
        host.send(16'h0800, 16'h0000);
        chk("seg rearm", 16'h0200, w1 & 16'h0200);
    endtask : t_segment

    task automatic t_abs;
        abs_cmd = 1'b1;
        fork
            host.send(16'h0000, 16'h0000);
            begin
                @(posedge cv);
                #1 chk("abs refused", 16'h0001, 16'(refused));
            end
        join
        abs_cmd = 1'b0;
        prs = 1'b1;
        host.send(16'h0000, 16'h0000);
        prs = 1'b0;
        chk("preset", 16'h0000, w1 & 16'h0400);
        abs_cmd = 1'b1;
        fork
            host.send(16'h0000, 16'h0000);
            begin
                @(posedge cv);
                #1 chk("abs taken", 16'h0000, 16'(refused));
            end
        join
        abs_cmd = 1'b0;
    endtask : t_abs

    task automatic t_drive;
        host.send(16'h0000, 16'h8000);
        chk("drv en", 16'h8000, w2 & 16'h8080);
        chk("current", 16'h0001, 16'(cur_en));
        otemp = 1'b1;
        repeat (4) @(negedge clk);
        otemp = 1'b0;
        chk("drv fault", 16'h0080, w2 & 16'h0080);
        chk("no current", 16'h0000, 16'(cur_en));
        repeat (4) @(negedge clk);
        chk("fault held", 16'h0080, w2 & 16'h0080);
        host.send(16'h0400, 16'h0400);
        chk("fault clr", 16'h0000, w2 & 16'h8080);
        shrt = 1'b1;
        repeat (4) @(negedge clk);
        shrt = 1'b0;
        chk("short off", 16'h0000, w2 & 16'h0080);
    endtask : t_drive

    task automatic t_events;
        for (int i = 0; i < 12; i++) begin
            ev[tbl[i].idx] = 1'b1;
            @(negedge clk);
            if (!tbl[i].lvl) ev[tbl[i].idx] = 1'b0;
            repeat (3) @(negedge clk);
            chk($sformatf("event %0d", i), tbl[i].want,
                (tbl[i].w2 ? w2 : w1) & tbl[i].mask);
            ev[tbl[i].idx] = 1'b0;
            repeat (3) @(negedge clk);
        end
    endtask : t_events

    task automatic t_inputs;
        int   n;
        logic b;
        pins = 3'b101;
        repeat (4) @(negedge clk);
        chk("inputs", 16'h0005, w2 & 16'h0007);
        for (int k = 0; k < 2; k++) begin
            b = w2[11];
            n = 0;
            while (w2[11] === b && n < 40) begin
                @(negedge clk);
                n++;
            end
        end
        chk("beat", 16'h0010, 16'(n));
    endtask : t_inputs

    initial begin
        {rst_n, bad, mv, rng, cfg, cfg_ok, st_en} = 7'h00;
        {moving, accel, decel, ccw, done, otemp} = 6'h00;
        {abs_cmd, prs, shrt} = 3'b000;
        pins = 3'b000;
        ev = 16'h0000;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        t_reset();
        t_config();
        t_errors();
        t_motion();
        t_segment();
        t_abs();
        t_drive();
        t_inputs();
        t_events();
        end_of_test();
    end
endmodule : motion_status_words_tb
`default_nettype wire
